//--- logic/msp_pkg.sv
/*
  package for the motor start-up position-detect configuration block:
  register offsets, field positions, reset values, decoded types.
  assumes an axi4-lite master with 32-bit data on the register side.
*/
package msp_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  // offsets are word indexes; not all are multiples of four, so byte address is four times the index
  localparam int MSP_ADDR_W = 10;
  localparam logic [7:0] MSP_IDX_STARTUP_ONE = 8'h84;
  localparam logic [7:0] MSP_IDX_STARTUP_TWO = 8'h86;
  localparam logic [7:0] MSP_IDX_REVERSE_SET = 8'h88;
  localparam logic [7:0] MSP_IDX_GENERAL_LIMIT = 8'h8c;
  localparam logic [9:0] MSP_ADDR_STARTUP_ONE = {MSP_IDX_STARTUP_ONE, 2'b00};
  localparam logic [9:0] MSP_ADDR_STARTUP_TWO = {MSP_IDX_STARTUP_TWO, 2'b00};
  localparam logic [9:0] MSP_ADDR_REVERSE_SET = {MSP_IDX_REVERSE_SET, 2'b00};
  localparam logic [9:0] MSP_ADDR_GENERAL_LIMIT = {MSP_IDX_GENERAL_LIMIT, 2'b00};
  localparam logic [31:0] MSP_RESET_STARTUP_ONE = 32'h0000_0000;
  localparam logic [31:0] MSP_RESET_STARTUP_TWO = 32'h0000_0000;
  localparam logic [31:0] MSP_RESET_REVERSE_SET = 32'h0000_0000;
  localparam logic [3:0] MSP_RESET_GENERAL_LIMIT = 4'h0;

  // ----------------------------------------------------------------------
  // field positions in the first start-up word
  // ----------------------------------------------------------------------
  localparam int MSP_THR_LSB = 9;
  localparam int MSP_THR_MSB = 13;
  localparam int MSP_RELEASE_BIT = 8;
  localparam int MSP_ANGLE_LSB = 6;
  localparam int MSP_REPEAT_LSB = 4;
  localparam int MSP_LIMIT_SRC_BIT = 3;
  localparam int MSP_RAMPDOWN_BIT = 2;
  localparam int MSP_BRAKE_BIT = 1;
  localparam int MSP_REV_SEL_BIT = 0;
  localparam int MSP_METHOD_LSB = 29;
  localparam logic [1:0] MSP_METHOD_POSITION_DETECT = 2'h2;
  localparam logic [4:0] MSP_THR_MAX_CODE = 5'h11;

  // ----------------------------------------------------------------------
  // field positions in the second word / reverse set (open loop, a1, a2)
  // ----------------------------------------------------------------------
  localparam int MSP_OL_LIMIT_LSB = 27;
  localparam int MSP_ACCEL_LIN_LSB = 23;
  localparam int MSP_ACCEL_QUAD_LSB = 19;

  // threshold in milliamps per code, largest 8000 fits 14 bits
  localparam int MSP_MA_W = 14;

  typedef enum logic [1:0]
  {
    MSP_AX_IDLE = 2'b00,
    MSP_AX_WRESP = 2'b01,
    MSP_AX_RRESP = 2'b10
  } msp_axi_state_t;

  typedef struct packed
  {
    logic [MSP_MA_W-1:0] threshold_ma;   // position detect current threshold
    logic threshold_valid;               // code is a defined value
    logic release_tristate;              // 1 tristate, 0 brake
    logic [6:0] advance_angle_deg;       // 0,30,60,90
    logic [2:0] run_count;               // 1..4 runs
    logic position_detect_active;        // start-up method is position detect
    logic [3:0] open_loop_limit_code;    // effective open-loop limit code
    logic torque_rampdown_enable;        // ramp iq down before closed loop
    logic active_brake_enable;           // active braking allowed
    logic [3:0] open_loop_accel_linear;  // effective a1 code
    logic [3:0] open_loop_accel_quadratic; // effective a2 code
  } msp_ctrl_t;

  typedef struct packed
  {
    logic [31:0] startup_one;
    logic [31:0] startup_two;
    logic [31:0] reverse_set;
    logic [3:0] general_limit;
    msp_axi_state_t ax_state;
    logic awvalid_seen;
    logic [MSP_ADDR_W-1:0] awaddr;
    logic wvalid_seen;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] resp;
    logic [31:0] rdata;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    msp_ctrl_t ctrl;
  } msp_state_t;

endpackage

//--- logic/msp_startup_cfg.sv
/*
  motor start-up settings registers with the position-detect fields decoded
  into ready-to-use controls for the start-up sequencer.
  assumes one 20 mhz clock, synchronous active-high reset and an axi4-lite
  master that keeps at most one write and one read under way.
*/
`timescale 1ns/1ns
module msp_startup_cfg
#(
  parameter int ADDR_W = 10 // byte address width of the register window
)
(
  input wire logic sys_clk, // 20 mhz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output msp_pkg::msp_ctrl_t ctrl // decoded start-up controls
);
  import msp_pkg::*;

  // refuse an address width too narrow to reach the highest register
  if (ADDR_W < MSP_ADDR_W)
  begin
    $error("ADDR_W must reach the register window");
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // threshold table in milliamps; undefined codes give zero
  function automatic logic [MSP_MA_W-1:0] thr_ma(input logic [4:0] code);
    logic [MSP_MA_W-1:0] r;
    r = '0;
    case (code)
      5'h00: r = 14'd250;
      5'h01: r = 14'd500;
      5'h02: r = 14'd750;
      5'h03: r = 14'd1000;
      5'h04: r = 14'd1250;
      5'h05: r = 14'd1500;
      5'h06: r = 14'd2000;
      5'h07: r = 14'd2500;
      5'h08: r = 14'd3000;
      5'h09: r = 14'd3667;
      5'h0a: r = 14'd4000;
      5'h0b: r = 14'd4667;
      5'h0c: r = 14'd5000;
      5'h0d: r = 14'd5333;
      5'h0e: r = 14'd6000;
      5'h0f: r = 14'd6667;
      5'h10: r = 14'd7333;
      5'h11: r = 14'd8000;
      default: r = '0;
    endcase
    return r;
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction

  // decode a byte address; 3'h7 means unmapped
  function automatic logic [2:0] sel(input logic [MSP_ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h7;
    case (a)
      MSP_ADDR_STARTUP_ONE: r = 3'h0;
      MSP_ADDR_STARTUP_TWO: r = 3'h1;
      MSP_ADDR_REVERSE_SET: r = 3'h2;
      MSP_ADDR_GENERAL_LIMIT: r = 3'h3;
      default: r = 3'h7;
    endcase
    return r;
  endfunction

  msp_state_t st;
  msp_state_t next_st;

  // ----------------------------------------------------------------------
  // next-state logic: bus slave plus control decode
  // ----------------------------------------------------------------------
  // write address and data are caught separately so either order works
  always_comb
  begin
    logic [31:0] w1;
    logic [31:0] src;
    logic [2:0] rs;
    w1 = '0;
    src = '0;
    rs = '0;
    next_st = st;
    if (s_axi_awvalid && st.awready)
    begin
      next_st.awvalid_seen = 1'b1;
      next_st.awaddr = s_axi_awaddr[MSP_ADDR_W-1:0];
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.wvalid_seen = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    case (st.ax_state)
      MSP_AX_IDLE:
      begin
        if (st.awvalid_seen && st.wvalid_seen)
        begin
          next_st.resp = 2'b00;
          case (sel(st.awaddr))
            3'h0: next_st.startup_one = merge(st.startup_one, st.wdata, st.wstrb);
            3'h1: next_st.startup_two = merge(st.startup_two, st.wdata, st.wstrb);
            3'h2: next_st.reverse_set = merge(st.reverse_set, st.wdata, st.wstrb);
            3'h3:
            begin
              if (st.wstrb[0])
                next_st.general_limit = st.wdata[3:0];
            end
            default: next_st.resp = 2'b10; // unmapped answers slverr
          endcase
          next_st.awvalid_seen = 1'b0;
          next_st.wvalid_seen = 1'b0;
          next_st.bvalid = 1'b1;
          next_st.arready = 1'b0;
          next_st.ax_state = MSP_AX_WRESP;
        end
        else if (s_axi_arvalid && st.arready && !st.awvalid_seen && !st.wvalid_seen)
        begin
          rs = sel(s_axi_araddr[MSP_ADDR_W-1:0]);
          next_st.resp = 2'b00;
          case (rs)
            3'h0: next_st.rdata = st.startup_one;
            3'h1: next_st.rdata = st.startup_two;
            3'h2: next_st.rdata = st.reverse_set;
            3'h3: next_st.rdata = {28'h0000000, st.general_limit};
            default:
            begin
              next_st.rdata = '0;
              next_st.resp = 2'b10;
            end
          endcase
          next_st.arready = 1'b0;
          next_st.rvalid = 1'b1;
          next_st.ax_state = MSP_AX_RRESP;
        end
      end
      MSP_AX_WRESP:
      begin
        if (s_axi_bready)
        begin
          next_st.bvalid = 1'b0;
          next_st.awready = 1'b1;
          next_st.wready = 1'b1;
          next_st.arready = 1'b1;
          next_st.ax_state = MSP_AX_IDLE;
        end
      end
      MSP_AX_RRESP:
      begin
        if (s_axi_rready)
        begin
          next_st.rvalid = 1'b0;
          next_st.arready = 1'b1;
          next_st.ax_state = MSP_AX_IDLE;
        end
      end
      default: next_st.ax_state = MSP_AX_IDLE;
    endcase
    // hold arready low while a write is caught, so no read handshake is ever dropped
    if (next_st.awvalid_seen || next_st.wvalid_seen)
      next_st.arready = 1'b0;

    // controls are decoded from the words being committed, so both update on one edge
    w1 = next_st.startup_one;
    next_st.ctrl.threshold_ma = thr_ma(w1[MSP_THR_MSB:MSP_THR_LSB]);
    next_st.ctrl.threshold_valid = (w1[MSP_THR_MSB:MSP_THR_LSB] <= MSP_THR_MAX_CODE);
    next_st.ctrl.release_tristate = w1[MSP_RELEASE_BIT];
    next_st.ctrl.advance_angle_deg = 7'(30 * w1[MSP_ANGLE_LSB +: 2]);
    next_st.ctrl.run_count = {1'b0, w1[MSP_REPEAT_LSB +: 2]} + 3'h1;
    next_st.ctrl.position_detect_active =
      (w1[MSP_METHOD_LSB +: 2] == MSP_METHOD_POSITION_DETECT);
    // reverse selection swaps in the reverse word's fields as a group
    src = w1[MSP_REV_SEL_BIT] ? next_st.reverse_set : next_st.startup_two;
    next_st.ctrl.open_loop_limit_code = w1[MSP_LIMIT_SRC_BIT] ? next_st.general_limit
                                        : src[MSP_OL_LIMIT_LSB +: 4];
    next_st.ctrl.open_loop_accel_linear = src[MSP_ACCEL_LIN_LSB +: 4];
    next_st.ctrl.open_loop_accel_quadratic = src[MSP_ACCEL_QUAD_LSB +: 4];
    next_st.ctrl.torque_rampdown_enable = w1[MSP_RAMPDOWN_BIT];
    next_st.ctrl.active_brake_enable = w1[MSP_BRAKE_BIT];
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.startup_one <= MSP_RESET_STARTUP_ONE;
      st.startup_two <= MSP_RESET_STARTUP_TWO;
      st.reverse_set <= MSP_RESET_REVERSE_SET;
      st.general_limit <= MSP_RESET_GENERAL_LIMIT;
      st.ctrl.threshold_ma <= 14'd250;
      st.ctrl.threshold_valid <= 1'b1;
      st.ctrl.run_count <= 3'h1;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.ax_state <= MSP_AX_IDLE;
    end
    else
      st <= next_st;
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_arready = st.arready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.resp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.resp;
  assign s_axi_rdata = st.rdata;
  assign ctrl = st.ctrl;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_thr_max;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.startup_one[MSP_THR_MSB:MSP_THR_LSB] == 5'h11) |-> (ctrl.threshold_ma == 14'd8000);
  endproperty
  a_thr_max: assert property (p_thr_max) else $error("threshold code 11h not 8000 mA");
  property p_thr_invalid;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.startup_one[MSP_THR_MSB:MSP_THR_LSB] > 5'h11) |-> !ctrl.threshold_valid;
  endproperty
  a_thr_invalid: assert property (p_thr_invalid) else $error("undefined threshold not flagged");
  property p_release;
    @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |-> (ctrl.release_tristate == st.startup_one[MSP_RELEASE_BIT]);
  endproperty
  a_release: assert property (p_release) else $error("release mode mismatch");
  property p_angle;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.startup_one[7:6] == 2'h3) |-> (ctrl.advance_angle_deg == 7'd90);
  endproperty
  a_angle: assert property (p_angle) else $error("advance angle not 90");
  property p_repeat;
    @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |-> (ctrl.run_count == {1'b0, st.startup_one[5:4]} + 3'h1);
  endproperty
  a_repeat: assert property (p_repeat) else $error("run count mismatch");
  property p_limit_src;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.startup_one[3] && st.startup_one[3] == next_st.startup_one[3]
       && st.general_limit == next_st.general_limit)
      |=> (ctrl.open_loop_limit_code == $past(st.general_limit));
  endproperty
  a_limit_src: assert property (p_limit_src) else $error("general limit not used");
  property p_ramp_brake;
    @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |-> (ctrl.torque_rampdown_enable == st.startup_one[2]
                && ctrl.active_brake_enable == st.startup_one[1]);
  endproperty
  a_ramp_brake: assert property (p_ramp_brake) else $error("rampdown or brake mismatch");
  property p_rev;
    @(posedge sys_clk) disable iff (sys_rst)
      (st.startup_one[0] && next_st.startup_one[0] && st.reverse_set == next_st.reverse_set)
      |=> (ctrl.open_loop_accel_linear == $past(st.reverse_set[26:23]));
  endproperty
  a_rev: assert property (p_rev) else $error("reverse set not applied");
  property p_method;
    @(posedge sys_clk) disable iff (sys_rst)
      1'b1 |-> (ctrl.position_detect_active == (st.startup_one[30:29] == 2'h2));
  endproperty
  a_method: assert property (p_method) else $error("position detect method not seen");
  property p_readback;
    @(posedge sys_clk) disable iff (sys_rst)
      (s_axi_arvalid && s_axi_arready && !st.awvalid_seen && !st.wvalid_seen
       && s_axi_araddr[MSP_ADDR_W-1:0] == MSP_ADDR_STARTUP_ONE)
      |=> (s_axi_rvalid && s_axi_rdata == $past(st.startup_one));
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs from stored word");
  c_write: cover property (@(posedge sys_clk) s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge sys_clk) s_axi_rvalid && s_axi_rready);
  c_rev: cover property (@(posedge sys_clk) ctrl.position_detect_active && st.startup_one[0]);
endmodule

//--- dv/test_msp_startup_cfg.sv
/*
  bench for msp_startup_cfg: axi4-lite master tasks and register tests.
  assumes one clock, synchronous reset, answers within a few cycles.
*/
`timescale 1ns/1ns
module test_msp_startup_cfg;
  import msp_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [MSP_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  msp_ctrl_t ctrl;
  int failures = 0;
  int num_checks = 0;
  int thr_ma [18] = '{250, 500, 750, 1000, 1250, 1500, 2000, 2500, 3000, 3667, 4000, 4667, 5000, 5333,
    6000, 6667, 7333, 8000};

  msp_startup_cfg dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ctrl(ctrl));

  // 50 ns period
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // report and compare
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // bus master; each task waits one edge first so no signal is set twice
  // ----------------------------------------------------------------------
  task automatic wr(input logic [MSP_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        chk("bresp", 32'(er), 32'(bresp));
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
    begin
      failures++;
      test_done();
    end
  endtask

  task automatic rd(input logic [MSP_ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
    begin
      failures++;
      test_done();
    end
  endtask

  // writes the first word and waits until the decode has settled
  task automatic wr_one(input logic [31:0] d);
    wr(MSP_ADDR_STARTUP_ONE, d, 4'hf, 2'b00);
    tick(2);
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    logic [31:0] w;
    logic rev, src;
    int lim;
    tick(6);
    sys_rst <= 1'b0;
    // reset values of registers and decoded controls
    rd(MSP_ADDR_STARTUP_ONE, MSP_RESET_STARTUP_ONE, 2'b00);
    rd(MSP_ADDR_STARTUP_TWO, MSP_RESET_STARTUP_TWO, 2'b00);
    rd(MSP_ADDR_REVERSE_SET, MSP_RESET_REVERSE_SET, 2'b00);
    rd(MSP_ADDR_GENERAL_LIMIT, 32'(MSP_RESET_GENERAL_LIMIT), 2'b00);
    chk("threshold_ma", 32'd250, 32'(ctrl.threshold_ma));
    chk("run_count", 32'd1, 32'(ctrl.run_count));
    chk("detect_active", 32'd0, 32'(ctrl.position_detect_active));
    $display("test reset done");
    // every threshold code, defined and undefined, with read-back
    for (int c = 0; c < 32; c++)
    begin
      w = 32'h4000_0000 | (32'(c) << MSP_THR_LSB);
      wr_one(w);
      rd(MSP_ADDR_STARTUP_ONE, w, 2'b00);
      chk("threshold_ma", (c < 18) ? 32'(thr_ma[c]) : 32'd0, 32'(ctrl.threshold_ma));
      chk("threshold_valid", 32'(c < 18), 32'(ctrl.threshold_valid));
    end
    $display("test threshold done");
    // angle, repeat and the single-bit enables, all codes
    for (int i = 0; i < 4; i++)
    begin
      w = 32'h4000_0000 | (32'(i) << MSP_ANGLE_LSB) | (32'(3 - i) << MSP_REPEAT_LSB);
      w = w | (32'(i % 2) << MSP_RELEASE_BIT) | (32'(i / 2) << MSP_RAMPDOWN_BIT) | (32'(i % 2) << MSP_BRAKE_BIT);
      wr_one(w);
      chk("advance_angle", 32'(30 * i), 32'(ctrl.advance_angle_deg));
      chk("run_count", 32'(4 - i), 32'(ctrl.run_count));
      chk("release_tristate", 32'(i % 2), 32'(ctrl.release_tristate));
      chk("rampdown", 32'(i / 2), 32'(ctrl.torque_rampdown_enable));
      chk("active_brake", 32'(i % 2), 32'(ctrl.active_brake_enable));
    end
    $display("test fields done");
    // limit source and parameter set; general limit keeps lane 0 low nibble only
    wr(MSP_ADDR_STARTUP_TWO, (32'd5 << MSP_OL_LIMIT_LSB) | (32'd6 << MSP_ACCEL_LIN_LSB)
      | (32'd7 << MSP_ACCEL_QUAD_LSB), 4'hf, 2'b00);
    wr(MSP_ADDR_REVERSE_SET, (32'd9 << MSP_OL_LIMIT_LSB) | (32'd10 << MSP_ACCEL_LIN_LSB)
      | (32'd11 << MSP_ACCEL_QUAD_LSB), 4'hf, 2'b00);
    wr(MSP_ADDR_GENERAL_LIMIT, 32'hffff_ff53, 4'h1, 2'b00);
    rd(MSP_ADDR_GENERAL_LIMIT, 32'h0000_0003, 2'b00);
    for (int k = 0; k < 4; k++)
    begin
      src = k[1];
      rev = k[0];
      wr_one(32'h4000_0000 | (32'(src) << MSP_LIMIT_SRC_BIT) | (32'(rev) << MSP_REV_SEL_BIT));
      lim = src ? 3 : (rev ? 9 : 5);
      chk("open_loop_limit", 32'(lim), 32'(ctrl.open_loop_limit_code));
      chk("accel_linear", rev ? 32'd10 : 32'd6, 32'(ctrl.open_loop_accel_linear));
      chk("accel_quadratic", rev ? 32'd11 : 32'd7, 32'(ctrl.open_loop_accel_quadratic));
    end
    $display("test limit source done");
    // start-up method codes
    for (int m = 0; m < 4; m++)
    begin
      wr_one(32'(m) << MSP_METHOD_LSB);
      chk("detect_active", 32'(m == 2), 32'(ctrl.position_detect_active));
    end
    $display("test method done");
    // unmapped place is refused and stores nothing
    wr(10'h240, 32'hdead_beef, 4'hf, 2'b10);
    rd(10'h240, 32'h0, 2'b10);
    rd(MSP_ADDR_STARTUP_ONE, 32'h6000_0000, 2'b00);
    $display("test unmapped done");
    // second reset in mid-run clears everything again
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    tick(6);
    sys_rst <= 1'b0;
    rd(MSP_ADDR_STARTUP_ONE, 32'h0, 2'b00);
    rd(MSP_ADDR_GENERAL_LIMIT, 32'h0, 2'b00);
    chk("threshold_ma", 32'd250, 32'(ctrl.threshold_ma));
    $display("test second reset done");
    test_done();
  end
endmodule
